// File: verilog/two_wire_config_register_slave.sv
// Two-wire bus slave giving a host access to the configuration registers
`timescale 1ns/1ps
// Operation
// - Each register read advances the register pointer by one.
// - Device answers to the 7-bit address on its address-select pins.
// - Device watches for start and ignores the bus until one occurs.
// - Address is followed by direction bit: one reads, zero writes.
// - On address match device acknowledges, then moves data bytes.
// - Stop, SDA rising while SCL high, releases bus and returns to idle.
// - Repeated start is accepted in place of stop, with new address.
// - Written bits are sampled on the delayed SCL rising edge.
// - SCL is filtered over three crystal periods against glitches, delayed up to six.
// - Read data changes only after the delayed SCL falling edge.
// - Write transaction first byte is address plus direction bit zero.
// - Byte after the address byte sets the pointer; next is stored.
// - Pointer increments after each written byte for sequential fills.
// - Data line is only pulled low or released, open drain.
module two_wire_config_register_slave (
	// System clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Crystal clock for the bus side
	input wire logic xtal_clk_i,
	// Bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic [two_wire_pkg::DEV_ADDR_W-1:0] bus_address_select_pins_i,
	// Register file port
	output logic reg_wr_en_o,
	output logic [two_wire_pkg::REG_ADDR_W-1:0] reg_addr_o,
	output logic [two_wire_pkg::DATA_W-1:0] reg_wdata_o,
	input wire logic [two_wire_pkg::DATA_W-1:0] reg_rdata_i
);
	import two_wire_pkg::*;

	logic scl_f;
	logic sda_f;
	logic scl_q_reg;
	logic sda_q_reg;
	logic [DEV_ADDR_W-1:0] pins_s1_reg;
	logic [DEV_ADDR_W-1:0] pins_s2_reg;
	link_state_e state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic rw_reg;
	logic drive_low_reg;
	logic host_ack_reg;
	logic [REG_ADDR_W-1:0] ptr_reg;
	logic [DATA_W-1:0] rd_byte_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic bus_ev;
	logic byte_done;
	logic addr_match;
	logic rd_launch;
	logic wr_launch;
	logic ptr_load;
	logic req_start;
	reg_req_s req_word;
	logic req_busy;
	logic req_done;
	logic [DATA_W-1:0] req_resp;
	logic sys_valid;
	reg_req_s sys_word;
	logic sys_ack_reg;
	logic rd_pend_reg;
	logic [DATA_W-1:0] sys_resp_reg;

	// Each line has its own filter of the same length so start and stop keep their ordering
	line_deglitch #(.STABLE_CYCLES(FILTER_CYCLES), .RESET_LEVEL(LINE_IDLE)) u_scl_filter (
		.clk_i(xtal_clk_i),
		.rst_i(rst_i),
		.d_i(scl_i),
		.q_o(scl_f)
	);

	line_deglitch #(.STABLE_CYCLES(FILTER_CYCLES), .RESET_LEVEL(LINE_IDLE)) u_sda_filter (
		.clk_i(xtal_clk_i),
		.rst_i(rst_i),
		.d_i(sda_i),
		.q_o(sda_f)
	);

	always_ff @(posedge xtal_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pins_s1_reg <= PINS_RESET;
			pins_s2_reg <= PINS_RESET;
		end
		else
		begin
			pins_s1_reg <= bus_address_select_pins_i;
			pins_s2_reg <= pins_s1_reg;
		end
	end

	always_ff @(posedge xtal_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			scl_q_reg <= LINE_IDLE;
			sda_q_reg <= LINE_IDLE;
		end
		else
		begin
			scl_q_reg <= scl_f;
			sda_q_reg <= sda_f;
		end
	end

	assign scl_rise = scl_f && !scl_q_reg;
	assign scl_fall = !scl_f && scl_q_reg;
	assign start_ev = scl_f && scl_q_reg && sda_q_reg && !sda_f;
	assign stop_ev = scl_f && scl_q_reg && !sda_q_reg && sda_f;
	assign bus_ev = start_ev || stop_ev;
	assign byte_done = scl_fall && (bit_cnt_reg == BYTE_BITS) && !bus_ev;
	assign addr_match = (shift_reg[7:1] == pins_s2_reg);

	// Read prefetch when a matching read address byte ends and on each host ack
	assign rd_launch = !bus_ev && (
		(state_reg == ST_ADDR && byte_done && addr_match && shift_reg[0]) ||
		(state_reg == ST_RACK && scl_rise && !sda_f));
	assign wr_launch = state_reg == ST_WDATA && byte_done && !req_busy;
	assign ptr_load = state_reg == ST_PTR && byte_done;
	assign req_start = rd_launch || wr_launch;

	always_comb
	begin
		req_word.write = wr_launch;
		req_word.addr = ptr_reg;
		req_word.data = shift_reg;
	end

	always_ff @(posedge xtal_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= CNT_RESET;
			shift_reg <= BYTE_RESET;
			rw_reg <= 1'b0;
			drive_low_reg <= 1'b0;
			host_ack_reg <= 1'b0;
		end
		else if (stop_ev)
		begin
			state_reg <= ST_IDLE;
			drive_low_reg <= 1'b0;
		end
		else if (start_ev)
		begin
			state_reg <= ST_ADDR;
			bit_cnt_reg <= CNT_RESET;
			drive_low_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					drive_low_reg <= 1'b0;
				end
				ST_ADDR, ST_PTR, ST_WDATA:
				begin
					if (scl_rise && bit_cnt_reg != BYTE_BITS)
					begin
						shift_reg <= {shift_reg[6:0], sda_f};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					else if (byte_done)
					begin
						if (state_reg == ST_ADDR)
						begin
							if (addr_match)
							begin
								rw_reg <= shift_reg[0];
								drive_low_reg <= 1'b1;
								state_reg <= ST_AACK;
							end
							else
								state_reg <= ST_IDLE;
						end
						else if (state_reg == ST_PTR)
						begin
							drive_low_reg <= 1'b1;
							state_reg <= ST_PACK;
						end
						else
						begin
							// A byte that cannot be handed over is refused with no-ack
							drive_low_reg <= !req_busy;
							state_reg <= ST_WACK;
						end
					end
				end
				ST_AACK, ST_PACK, ST_WACK:
				begin
					if (scl_fall)
					begin
						bit_cnt_reg <= CNT_RESET;
						if (state_reg == ST_AACK && rw_reg)
						begin
							shift_reg <= rd_byte_reg;
							drive_low_reg <= ~rd_byte_reg[7];
							state_reg <= ST_RDATA;
						end
						else
						begin
							drive_low_reg <= 1'b0;
							state_reg <= (state_reg == ST_AACK) ? ST_PTR : ST_WDATA;
						end
					end
				end
				ST_RDATA:
				begin
					if (scl_rise)
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					else if (scl_fall)
					begin
						if (bit_cnt_reg == BYTE_BITS)
						begin
							drive_low_reg <= 1'b0;
							state_reg <= ST_RACK;
						end
						else
						begin
							shift_reg <= {shift_reg[6:0], 1'b0};
							drive_low_reg <= ~shift_reg[6];
						end
					end
				end
				ST_RACK:
				begin
					if (scl_rise)
						host_ack_reg <= !sda_f;
					else if (scl_fall)
					begin
						bit_cnt_reg <= CNT_RESET;
						if (host_ack_reg)
						begin
							shift_reg <= rd_byte_reg;
							drive_low_reg <= ~rd_byte_reg[7];
							state_reg <= ST_RDATA;
						end
						else
							state_reg <= ST_IDLE;
					end
				end
				default:
				begin
					state_reg <= ST_IDLE;
					drive_low_reg <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge xtal_clk_i or posedge rst_i)
	begin
		if (rst_i)
			ptr_reg <= PTR_RESET;
		else if (ptr_load)
			ptr_reg <= shift_reg;
		else if (req_start && !req_busy)
			ptr_reg <= ptr_reg + 8'h01;
	end

	always_ff @(posedge xtal_clk_i or posedge rst_i)
	begin
		if (rst_i)
			rd_byte_reg <= BYTE_RESET;
		else if (req_done)
			rd_byte_reg <= req_resp;
	end

	// Only ever pulls low; a high level is left to the pull-up
	always_ff @(posedge xtal_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sda_o <= 1'b0;
			sda_oe_n_o <= 1'b1;
		end
		else
		begin
			sda_o <= 1'b0;
			sda_oe_n_o <= ~drive_low_reg;
		end
	end

	req_handshake #(.REQ_W(REQ_W), .RESP_W(DATA_W)) u_crossing (
		.rst_i(rst_i),
		.src_clk_i(xtal_clk_i),
		.src_start_i(req_start),
		.src_word_i(req_word),
		.src_busy_o(req_busy),
		.src_done_o(req_done),
		.src_resp_o(req_resp),
		.dst_clk_i(clk_i),
		.dst_valid_o(sys_valid),
		.dst_word_o(sys_word),
		.dst_ack_i(sys_ack_reg),
		.dst_resp_i(sys_resp_reg)
	);

	// Register file side; read data is taken one cycle after the address
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			reg_wr_en_o <= 1'b0;
			reg_addr_o <= PTR_RESET;
			reg_wdata_o <= BYTE_RESET;
			rd_pend_reg <= 1'b0;
			sys_ack_reg <= 1'b0;
			sys_resp_reg <= BYTE_RESET;
		end
		else
		begin
			reg_wr_en_o <= sys_valid && sys_word.write;
			rd_pend_reg <= sys_valid && !sys_word.write;
			sys_ack_reg <= (sys_valid && sys_word.write) || rd_pend_reg;
			if (sys_valid)
			begin
				reg_addr_o <= sys_word.addr;
				reg_wdata_o <= sys_word.data;
			end
			if (rd_pend_reg)
				sys_resp_reg <= reg_rdata_i;
		end
	end

	property p_idle_holds;
		@(posedge xtal_clk_i) disable iff (rst_i)
		(state_reg == ST_IDLE && !start_ev) |=> (state_reg == ST_IDLE && !drive_low_reg);
	endproperty
	a_idle_holds: assert property (p_idle_holds)
		else $error("left idle without a start condition");

	property p_stop_releases;
		@(posedge xtal_clk_i) disable iff (rst_i)
		stop_ev |=> (state_reg == ST_IDLE) ##1 sda_oe_n_o;
	endproperty
	a_stop_releases: assert property (p_stop_releases)
		else $error("bus not released after stop");

	property p_restart;
		@(posedge xtal_clk_i) disable iff (rst_i)
		(start_ev && !stop_ev) |=> (state_reg == ST_ADDR && bit_cnt_reg == CNT_RESET);
	endproperty
	a_restart: assert property (p_restart)
		else $error("start did not restart address phase");

	property p_match_ack;
		@(posedge xtal_clk_i) disable iff (rst_i)
		(state_reg == ST_ADDR && byte_done && addr_match) |=> drive_low_reg ##1 !sda_oe_n_o;
	endproperty
	a_match_ack: assert property (p_match_ack)
		else $error("matching address not acknowledged");

	property p_mismatch;
		@(posedge xtal_clk_i) disable iff (rst_i)
		(state_reg == ST_ADDR && byte_done && !addr_match) |=> (state_reg == ST_IDLE && !drive_low_reg);
	endproperty
	a_mismatch: assert property (p_mismatch)
		else $error("foreign address acknowledged");

	property p_change_on_fall;
		@(posedge xtal_clk_i) disable iff (rst_i)
		(drive_low_reg != $past(drive_low_reg) && !$past(bus_ev)) |-> $past(scl_fall);
	endproperty
	a_change_on_fall: assert property (p_change_on_fall)
		else $error("data line changed away from a falling clock");

	property p_ptr_advance;
		@(posedge xtal_clk_i) disable iff (rst_i)
		(req_start && !req_busy) |=> (ptr_reg == $past(ptr_reg) + 8'h01);
	endproperty
	a_ptr_advance: assert property (p_ptr_advance)
		else $error("pointer did not advance after a transfer");

	property p_ptr_load;
		@(posedge xtal_clk_i) disable iff (rst_i)
		ptr_load |=> (ptr_reg == $past(shift_reg));
	endproperty
	a_ptr_load: assert property (p_ptr_load)
		else $error("pointer byte not loaded");

	property p_open_drain;
		@(posedge xtal_clk_i) disable iff (rst_i)
		!sda_oe_n_o |-> (sda_o == 1'b0 && $past(drive_low_reg));
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("data line driven high");

	property p_write_lands;
		@(posedge clk_i) disable iff (rst_i)
		(sys_valid && sys_word.write) |=> (reg_wr_en_o && reg_addr_o == $past(sys_word.addr));
	endproperty
	a_write_lands: assert property (p_write_lands)
		else $error("write strobe missing or at wrong register");

endmodule

// File: include/two_wire_pkg.sv
// Constants, states and carriers for the two-wire configuration register slave
package two_wire_pkg;

	// Input filter: least time a bus line must hold before it is believed
	localparam int FILTER_NS = 120;
	localparam int XTAL_PERIOD_NS = 40;
	localparam int FILTER_CYCLES = (FILTER_NS + XTAL_PERIOD_NS - 1) / XTAL_PERIOD_NS;

	localparam int DEV_ADDR_W = 7;
	localparam int REG_ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] CNT_RESET = 4'h0;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [6:0] PINS_RESET = 7'h00;
	localparam logic LINE_IDLE = 1'b1;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_AACK,
		ST_PTR,
		ST_PACK,
		ST_WDATA,
		ST_WACK,
		ST_RDATA,
		ST_RACK
	} link_state_e;

	typedef struct packed {
		logic write;
		logic [REG_ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} reg_req_s;

	localparam int REQ_W = $bits(reg_req_s);

endpackage

// File: verilog/line_deglitch.sv
// Two-flop synchroniser followed by a stability filter for one bus line
`timescale 1ns/1ps
module line_deglitch #(
	parameter int STABLE_CYCLES = two_wire_pkg::FILTER_CYCLES,
	parameter logic RESET_LEVEL = 1'b1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Line
	input wire logic d_i,
	output logic q_o
);
	import two_wire_pkg::*;

	logic sync1_reg;
	logic sync2_reg;
	logic [STABLE_CYCLES-1:0] hist_reg;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync1_reg <= RESET_LEVEL;
			sync2_reg <= RESET_LEVEL;
		end
		else
		begin
			sync1_reg <= d_i;
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			hist_reg <= {STABLE_CYCLES{RESET_LEVEL}};
		else
			hist_reg <= {hist_reg[STABLE_CYCLES-2:0], sync2_reg};
	end

	// Pulses shorter than the window never reach the output
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			q_o <= RESET_LEVEL;
		else if (&hist_reg)
			q_o <= 1'b1;
		else if (~|hist_reg)
			q_o <= 1'b0;
	end

	property p_filter_stable;
		@(posedge clk_i) disable iff (rst_i)
		(q_o != $past(q_o)) |-> ($past(&hist_reg) || $past(~|hist_reg));
	endproperty
	a_filter_stable: assert property (p_filter_stable)
		else $error("filtered line changed without a stable window");

endmodule

// File: verilog/req_handshake.sv
// Toggle handshake carrying a request word one way and an answer word back
`timescale 1ns/1ps
module req_handshake #(
	parameter int REQ_W = two_wire_pkg::REQ_W,
	parameter int RESP_W = two_wire_pkg::DATA_W
) (
	// Reset for both sides
	input wire logic rst_i,
	// Requesting side
	input wire logic src_clk_i,
	input wire logic src_start_i,
	input wire logic [REQ_W-1:0] src_word_i,
	output logic src_busy_o,
	output logic src_done_o,
	output logic [RESP_W-1:0] src_resp_o,
	// Serving side
	input wire logic dst_clk_i,
	output logic dst_valid_o,
	output logic [REQ_W-1:0] dst_word_o,
	input wire logic dst_ack_i,
	input wire logic [RESP_W-1:0] dst_resp_i
);
	import two_wire_pkg::*;

	logic req_tgl_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	logic ack_q_reg;
	logic req_s1_reg;
	logic req_s2_reg;
	logic req_q_reg;
	logic ack_tgl_reg;
	logic [REQ_W-1:0] word_reg;
	logic [RESP_W-1:0] resp_reg;

	// Word is held until the answer returns, so it is stable when sampled
	always_ff @(posedge src_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			req_tgl_reg <= 1'b0;
			word_reg <= '0;
			src_busy_o <= 1'b0;
		end
		else if (src_start_i && !src_busy_o)
		begin
			req_tgl_reg <= ~req_tgl_reg;
			word_reg <= src_word_i;
			src_busy_o <= 1'b1;
		end
		else if (src_done_o)
			src_busy_o <= 1'b0;
	end

	always_ff @(posedge src_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			ack_q_reg <= 1'b0;
		end
		else
		begin
			ack_s1_reg <= ack_tgl_reg;
			ack_s2_reg <= ack_s1_reg;
			ack_q_reg <= ack_s2_reg;
		end
	end

	assign src_done_o = ack_s2_reg ^ ack_q_reg;
	assign src_resp_o = resp_reg;

	always_ff @(posedge dst_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_q_reg <= 1'b0;
		end
		else
		begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			req_q_reg <= req_s2_reg;
		end
	end

	assign dst_valid_o = req_s2_reg ^ req_q_reg;
	assign dst_word_o = word_reg;

	always_ff @(posedge dst_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ack_tgl_reg <= 1'b0;
			resp_reg <= '0;
		end
		else if (dst_ack_i)
		begin
			ack_tgl_reg <= ~ack_tgl_reg;
			resp_reg <= dst_resp_i;
		end
	end

endmodule

// File: verif/two_wire_host.sv
// Behavioural host master that drives the bus clock and shares the data line
`timescale 1ns/1ps
module two_wire_host (
	// Clock
	input wire logic clk_i,
	// Bus
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_n_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end

	// Quarter bus period of 500 ns, far above filter and crossing delays
	task automatic wait_q(input int n);
		repeat (n * 50) @(posedge clk_i);
	endtask

	// Works from idle and as a repeated start from clock low
	task automatic start_cond();
		wait_q(1);
		sda_oe_n_o <= 1'b1;
		wait_q(1);
		scl_o <= 1'b1;
		wait_q(2);
		sda_oe_n_o <= 1'b0;
		wait_q(2);
		scl_o <= 1'b0;
	endtask

	// Short high pulse on the clock while low, well under the filter window
	task automatic scl_glitch(input int n);
		wait_q(1);
		scl_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		scl_o <= 1'b0;
	endtask

	task automatic stop_cond();
		wait_q(1);
		sda_oe_n_o <= 1'b0;
		wait_q(1);
		scl_o <= 1'b1;
		wait_q(2);
		sda_oe_n_o <= 1'b1;
		wait_q(2);
	endtask

	// Eight bits MSB first, then the acknowledge slot; a one releases the line
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
		begin
			wait_q(1);
			sda_oe_n_o <= tx[i];
			wait_q(1);
			scl_o <= 1'b1;
			wait_q(2);
			rx[i] = sda_i;
			scl_o <= 1'b0;
		end
	endtask
endmodule

// File: verif/two_wire_config_register_slave_tb.sv
// Self-checking bench for the two-wire configuration register slave
`timescale 1ns/1ps
module two_wire_config_register_slave_tb;
	import two_wire_pkg::*;
	localparam logic [6:0] DEV = 7'h2D;
	logic clk_i = 1'b0;
	logic xtal_clk = 1'b0;
	logic rst_i = 1'b1;
	logic scl;
	logic host_oe_n;
	logic sda;
	logic sda_o;
	logic sda_oe_n_o;
	logic reg_wr_en_o;
	logic [7:0] reg_addr_o;
	logic [7:0] reg_wdata_o;
	logic [7:0] reg_rdata_i;
	logic [6:0] bus_address_select_pins = DEV;
	logic [15:0] wr_q[$];
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;

	always #5 clk_i = ~clk_i;
	// Crystal clock, 48 ns, phase unrelated to the system clock
	initial
	begin
		#7;
		forever #24 xtal_clk = ~xtal_clk;
	end

	// Pull-up: the line is low whenever either party pulls it
	assign sda = host_oe_n & (sda_oe_n_o | sda_o);
	// Register file stand-in, contents are a simple function of the index
	assign reg_rdata_i = reg_addr_o ^ 8'h5A;

	two_wire_config_register_slave i_two_wire_config_register_slave (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.xtal_clk_i(xtal_clk),
		.scl_i(scl),
		.sda_i(sda),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o),
		.bus_address_select_pins_i(bus_address_select_pins),
		.reg_wr_en_o(reg_wr_en_o),
		.reg_addr_o(reg_addr_o),
		.reg_wdata_o(reg_wdata_o),
		.reg_rdata_i(reg_rdata_i)
	);

	two_wire_host i_two_wire_host (
		.clk_i(clk_i),
		.sda_i(sda),
		.scl_o(scl),
		.sda_oe_n_o(host_oe_n)
	);

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Landed writes are logged; the ceiling is about twice the expected run
	always @(posedge clk_i)
	begin
		cycles++;
		if (reg_wr_en_o === 1'b1)
			wr_q.push_back({reg_addr_o, reg_wdata_o});
		if (cycles == 60000)
		begin
			err_count++;
			finish_test();
		end
	end

	// Clocks with data held high form no start, so nothing may answer
	task automatic test_ignore();
		logic [8:0] rx;
		i_two_wire_host.xfer(9'h1FF, rx);
		check("no start", 16'(rx), 16'h01FF);
		$display("test ignore done");
	endtask

	task automatic test_write();
		logic [8:0] rx;
		logic [7:0] data [2] = '{8'hA5, 8'h3C};
		wr_q.delete();
		i_two_wire_host.start_cond();
		i_two_wire_host.xfer({DEV, 1'b0, 1'b1}, rx);
		check("addr ack", 16'(rx[0]), 16'h0000);
		// A 60 ns clock spike must not shift a stray bit into the pointer
		i_two_wire_host.scl_glitch(6);
		i_two_wire_host.xfer({8'h05, 1'b1}, rx);
		check("ptr ack", 16'(rx[0]), 16'h0000);
		foreach (data[i])
		begin
			i_two_wire_host.xfer({data[i], 1'b1}, rx);
			check("data ack", 16'(rx[0]), 16'h0000);
		end
		i_two_wire_host.stop_cond();
		check("released", 16'(sda_oe_n_o), 16'h0001);
		check("write count", 16'(wr_q.size()), 16'h0002);
		check("first write", wr_q[0], 16'h05A5);
		check("second write", wr_q[1], 16'h063C);
		$display("test write done");
	endtask

	// Pointer write, repeated start, two reads ending with no-ack
	task automatic test_read();
		logic [8:0] rx;
		wr_q.delete();
		i_two_wire_host.start_cond();
		i_two_wire_host.xfer({DEV, 1'b0, 1'b1}, rx);
		i_two_wire_host.xfer({8'h1A, 1'b1}, rx);
		check("ptr ack", 16'(rx[0]), 16'h0000);
		i_two_wire_host.start_cond();
		i_two_wire_host.xfer({DEV, 1'b1, 1'b1}, rx);
		check("read addr ack", 16'(rx[0]), 16'h0000);
		i_two_wire_host.xfer(9'h1FE, rx);
		check("read 1A", 16'(rx[8:1]), 16'h0040);
		i_two_wire_host.xfer(9'h1FF, rx);
		check("read 1B", 16'(rx[8:1]), 16'h0041);
		i_two_wire_host.stop_cond();
		check("released", 16'(sda_oe_n_o), 16'h0001);
		check("drive level", 16'(sda_o), 16'h0000);
		check("no writes", 16'(wr_q.size()), 16'h0000);
		$display("test read done");
	endtask

	// Neighbouring address first, then the pins move to that address
	task automatic test_mismatch();
		logic [8:0] rx;
		wr_q.delete();
		i_two_wire_host.start_cond();
		i_two_wire_host.xfer({7'h2C, 1'b0, 1'b1}, rx);
		check("other addr", 16'(rx[0]), 16'h0001);
		i_two_wire_host.xfer({8'h10, 1'b1}, rx);
		check("stays idle", 16'(rx[0]), 16'h0001);
		i_two_wire_host.stop_cond();
		check("no writes", 16'(wr_q.size()), 16'h0000);
		bus_address_select_pins <= 7'h2C;
		repeat (20) @(posedge clk_i);
		i_two_wire_host.start_cond();
		i_two_wire_host.xfer({7'h2C, 1'b0, 1'b1}, rx);
		check("new addr ack", 16'(rx[0]), 16'h0000);
		i_two_wire_host.xfer({8'h20, 1'b1}, rx);
		i_two_wire_host.xfer({8'h77, 1'b1}, rx);
		i_two_wire_host.stop_cond();
		check("write count", 16'(wr_q.size()), 16'h0001);
		check("write", wr_q[0], 16'h2077);
		$display("test mismatch done");
	endtask

	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (100) @(posedge clk_i);
		test_ignore();
		test_write();
		test_read();
		test_mismatch();
		finish_test();
	end
endmodule
